// ### design/tocu_top.sv
// output compare unit with axi4-lite register slave
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module tocu_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic [3:0] cap_in,
  output logic [tocu_pkg::NCH-1:0] pin_out,
  output logic [tocu_pkg::NCH-1:0] pin_oe,
  output logic irq
);
  import tocu_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [15:0] count_r;
  logic [15:0] cmp_r [NCH];
  logic [NCH-1:0] inh_r;
  logic [NCH-1:0] frc_r;
  logic [7:0] mask_r;
  logic [7:0] data_r;
  logic [7:0] act_r;
  logic [7:0] ien_r;
  logic [7:0] flag_r;
  logic [7:0] edge_r;
  logic sel_r;
  logic [7:0] lobuf_r;
  logic [NCH-1:0] pin_r;
  logic [NCH-1:0] oe_r;
  logic irq_r;
  logic [3:0] cs1_r;
  logic [3:0] cs2_r;
  logic [3:0] cs3_r;
  logic aw_r;
  logic bv_r;
  logic [1:0] br_r;
  logic ar_r;
  logic rv_r;
  logic [1:0] rr_r;
  logic [31:0] rd_r;

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  logic wr_fire;
  logic rd_fire;
  logic [7:0] wa;
  logic [7:0] ra;
  logic [NCH-1:0] cmp_wr;
  logic [NCH-1:0] cmp_hi;
  logic wr_ok;
  logic rd_ok;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [NCH-1:0] match;
  logic [3:0] cap_hit;
  logic [7:0] flag_nxt;
  logic [NCH-1:0] pin_nxt;
  logic [NCH-1:0] oe_nxt;
  tocu_act_s act [2:NCH];

  assign wr_fire = s_awvalid & s_wvalid & ~aw_r & ~bv_r;
  assign rd_fire = s_arvalid & ~ar_r & ~rv_r;
  assign wa = s_awaddr;
  assign ra = s_araddr;

  function automatic int unsigned cmp_idx(input logic [7:0] a);
    cmp_idx = int'((a - ADDR_CMP0) >> 2);
  endfunction

  function automatic logic is_cmp(input logic [7:0] a);
    is_cmp = (a >= ADDR_CMP0) && (a < ADDR_FORCE) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] st);
    merge16 = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
  endfunction

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      cmp_wr[i] = wr_fire && is_cmp(wa) && (cmp_idx(wa) == i)
                  && !(i == NCH-1 && sel_r);
      cmp_hi[i] = cmp_wr[i] & s_wstrb[1];
    end
  end

  always_comb begin
    case (wa)
      ADDR_COUNT, ADDR_FORCE, ADDR_MASK, ADDR_DATA, ADDR_ACT,
      ADDR_IEN, ADDR_FLAG, ADDR_EDGE, ADDR_SEL, ADDR_LOBUF: wr_ok = 1'b1;
      default: wr_ok = is_cmp(wa);
    endcase
    case (ra)
      ADDR_COUNT, ADDR_FORCE, ADDR_MASK, ADDR_DATA, ADDR_ACT,
      ADDR_IEN, ADDR_FLAG, ADDR_EDGE, ADDR_SEL, ADDR_LOBUF: rd_ok = 1'b1;
      default: rd_ok = is_cmp(ra);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r <= 1'b0;
      bv_r <= 1'b0;
      br_r <= RESP_OKAY;
    end else begin
      aw_r <= wr_fire;
      if (wr_fire) begin
        br_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      // response only after the address and data handshake
      if (aw_r) begin
        bv_r <= 1'b1;
      end else if (s_bready) begin
        bv_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_r <= 1'b0;
      rv_r <= 1'b0;
      rr_r <= RESP_OKAY;
      rd_r <= 32'h0;
    end else begin
      ar_r <= rd_fire;
      // read data only after the address handshake
      if (ar_r) begin
        rv_r <= 1'b1;
      end else if (s_rready) begin
        rv_r <= 1'b0;
      end
      if (rd_fire) begin
        rr_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        rd_r <= 32'h0;
        if (is_cmp(ra)) begin
          rd_r[15:0] <= cmp_r[cmp_idx(ra)];
        end else begin
          case (ra)
            ADDR_COUNT: rd_r[15:0] <= count_r;
            ADDR_MASK: rd_r[7:0] <= mask_r;
            ADDR_DATA: rd_r[7:0] <= data_r;
            ADDR_ACT: rd_r[7:0] <= act_r;
            ADDR_IEN: rd_r[7:0] <= ien_r;
            ADDR_FLAG: rd_r[7:0] <= flag_r;
            ADDR_EDGE: rd_r[7:0] <= edge_r;
            ADDR_SEL: rd_r[SEL_BIT] <= sel_r;
            ADDR_LOBUF: rd_r[7:0] <= lobuf_r;
            default: rd_r <= 32'h0;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter and coherent low byte buffer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= 16'h0;
      lobuf_r <= 8'h0;
    end else begin
      count_r <= count_r + 16'h1;
      if (rd_fire && ra == ADDR_COUNT) begin
        lobuf_r <= count_r[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // compare values, inhibit and capture four
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NCH; i++) begin
        cmp_r[i] <= CMP_RST;
      end
      inh_r <= '0;
    end else begin
      inh_r <= cmp_hi;
      for (int i = 0; i < NCH; i++) begin
        if (cmp_wr[i]) begin
          cmp_r[i] <= merge16(cmp_r[i], s_wdata, s_wstrb);
        end
      end
      if (sel_r && cap_hit[3]) begin
        cmp_r[NCH-1] <= count_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= 8'h0;
      data_r <= 8'h0;
      act_r <= 8'h0;
      ien_r <= 8'h0;
      edge_r <= 8'h0;
      sel_r <= 1'b0;
    end else if (wr_fire && s_wstrb[0]) begin
      case (wa)
        ADDR_MASK: mask_r <= s_wdata[7:0] & HI5_MASK;
        ADDR_DATA: data_r <= s_wdata[7:0] & HI5_MASK;
        ADDR_ACT: act_r <= s_wdata[7:0];
        ADDR_IEN: ien_r <= s_wdata[7:0];
        ADDR_EDGE: edge_r <= s_wdata[7:0];
        ADDR_SEL: sel_r <= s_wdata[SEL_BIT];
        default: ;
      endcase
    end
  end

  // force bits wait for the next count step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frc_r <= '0;
    end else if (wr_fire && s_wstrb[0] && wa == ADDR_FORCE) begin
      frc_r <= s_wdata[7:3];
    end else begin
      frc_r <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // matches, captures and flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs1_r <= 4'h0;
      cs2_r <= 4'h0;
      cs3_r <= 4'h0;
    end else begin
      cs1_r <= cap_in;
      cs2_r <= cs1_r;
      cs3_r <= cs2_r;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cap_hit[i] = tocu_edge(edge_r[2*i +: 2], cs2_r[i], cs3_r[i]);
    end
    for (int i = 0; i < NCH; i++) begin
      match[i] = (cmp_r[i] == count_r) && !inh_r[i];
    end
    match[NCH-1] = match[NCH-1] && !sel_r;
  end

  always_comb begin
    flag_set = {match[0], match[1], match[2], match[3], 4'h0};
    flag_set[3] = sel_r ? cap_hit[3] : match[4];
    flag_set[CAP_BIT:0] = {cap_hit[0], cap_hit[1], cap_hit[2]};
    flag_clr = (wr_fire && s_wstrb[0] && wa == ADDR_FLAG) ? s_wdata[7:0] : 8'h0;
    flag_nxt = (flag_r & ~flag_clr) | flag_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= 8'h0;
      irq_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      irq_r <= |(flag_r & ien_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin actions; pin index 0..4 is PA3..PA7
  always_comb begin
    for (int c = 2; c <= NCH; c++) begin
      act[c] = tocu_act_s'(act_r[2*(NCH-c) +: 2]);
    end
    pin_nxt = pin_r;
    oe_nxt = mask_r[7:3];
    for (int c = 2; c <= NCH; c++) begin
      if (!(c == NCH && sel_r)) begin
        oe_nxt[NCH-c] = oe_nxt[NCH-c] | (act[c] != ACT_OFF);
        if (match[c-1] || frc_r[NCH-c]) begin
          pin_nxt[NCH-c] = tocu_apply(act[c], pin_r[NCH-c]);
        end
      end
    end
    if (match[0] || frc_r[NCH-1]) begin
      for (int b = 0; b < NCH; b++) begin
        if (mask_r[3+b]) begin
          pin_nxt[b] = data_r[3+b];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_r <= '0;
      oe_r <= '0;
    end else begin
      pin_r <= pin_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign s_awready = aw_r;
  assign s_wready = aw_r;
  assign s_bvalid = bv_r;
  assign s_bresp = br_r;
  assign s_arready = ar_r;
  assign s_rvalid = rv_r;
  assign s_rresp = rr_r;
  assign s_rdata = rd_r;
  assign pin_out = pin_r;
  assign pin_oe = oe_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence force_one_s;
    wr_fire && s_wstrb[0] && wa == ADDR_FORCE && s_wdata[7] && mask_r[7] && !match[0];
  endsequence

  match_flag_a: assert property (match[0] |=> flag_r[7])
    else $error("match did not set flag");
  cmp_step_a: assert property (!sel_r ##1 (!sel_r && count_r == cmp_r[4] && !inh_r[4])
                               |=> flag_r[3])
    else $error("fifth compare missed");
  hi_inhibit_a: assert property (cmp_hi[1] ##1 !flag_r[6] |=> !flag_r[6])
    else $error("compare not inhibited");
  force_pin_a: assert property (force_one_s ##1 !cmp_wr[0] |=> pin_r[4] == $past(data_r[7]))
    else $error("force action missing");
  toggle_pin_a: assert property (match[1] && act[2] == ACT_TOG && !mask_r[6] && !match[0]
                                 |=> pin_r[3] != $past(pin_r[3]))
    else $error("toggle not taken");
  flag_clear_a: assert property (flag_clr[6] && !flag_set[6] |=> !flag_r[6])
    else $error("flag not cleared");
  count_run_a: assert property (1'b1 |=> count_r == $past(count_r) + 16'h1)
    else $error("counter not running");
  irq_gate_a: assert property (|(flag_r & ien_r) |=> irq_r)
    else $error("interrupt not raised");
  shared_quiet_a: assert property (sel_r && !mask_r[3] |=> $stable(pin_r[0]))
    else $error("shared pin moved as capture");
  lobuf_hold_a: assert property (rd_fire && ra == ADDR_COUNT |=> lobuf_r == $past(count_r[7:0]))
    else $error("low byte not latched");
endmodule
`default_nettype wire

// ### shared/tocu_pkg.sv
// constants, types and helpers of the timer output compare unit
package tocu_pkg;
  localparam int unsigned NCH = 5;
  localparam logic [15:0] CMP_RST = 16'hFFFF;
  localparam logic [7:0] ADDR_COUNT = 8'h00;
  localparam logic [7:0] ADDR_CMP0 = 8'h04;
  localparam logic [7:0] ADDR_FORCE = 8'h18;
  localparam logic [7:0] ADDR_MASK = 8'h1C;
  localparam logic [7:0] ADDR_DATA = 8'h20;
  localparam logic [7:0] ADDR_ACT = 8'h24;
  localparam logic [7:0] ADDR_IEN = 8'h28;
  localparam logic [7:0] ADDR_FLAG = 8'h2C;
  localparam logic [7:0] ADDR_EDGE = 8'h30;
  localparam logic [7:0] ADDR_SEL = 8'h34;
  localparam logic [7:0] ADDR_LOBUF = 8'h38;
  localparam int unsigned SEL_BIT = 2;
  localparam int unsigned CAP_BIT = 2;
  localparam logic [7:0] HI5_MASK = 8'hF8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic mode;
    logic level;
  } tocu_act_s;
  localparam tocu_act_s ACT_OFF = '{mode: 1'b0, level: 1'b0};
  localparam tocu_act_s ACT_TOG = '{mode: 1'b0, level: 1'b1};
  function automatic logic tocu_apply(input tocu_act_s a, input logic cur);
    unique case ({a.mode, a.level})
      2'h0: tocu_apply = cur;
      2'h1: tocu_apply = ~cur;
      2'h2: tocu_apply = 1'b0;
      default: tocu_apply = 1'b1;
    endcase
  endfunction
  function automatic logic tocu_edge(input logic [1:0] cfg, input logic cur, input logic prv);
    tocu_edge = (cfg[0] & cur & ~prv) | (cfg[1] & ~cur & prv);
  endfunction
endpackage

// ### sim/test_timer_output_compare_unit.sv
// self-checking bench of the output compare unit
`timescale 1ns/1ps
`default_nettype none
module test_timer_output_compare_unit;
  import tocu_pkg::*;
  logic aclk, aresetn;
  logic [7:0] s_awaddr, s_araddr;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [31:0] s_wdata, s_rdata, rd_d;
  logic [3:0] s_wstrb, cap_in;
  logic [1:0] s_bresp, s_rresp, rsp;
  logic [NCH-1:0] pin_out, pin_oe;
  logic irq;
  logic [15:0] last, c0;
  int bad_count, compares, i;
  logic [1:0] md [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
  logic ev [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  ////////////////////////////////////////////////////////////////
  tocu_top i_tocu_top (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .cap_in(cap_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic hang(input int n);
    if (n >= 300) begin
      bad_count++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1 && n < 300);
    rsp = s_bresp;
    s_bready <= 1'b0;
    hang(n);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_arready === 1'b1) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1 && n < 300);
    rd_d = s_rdata;
    rsp = s_rresp;
    s_arvalid <= 1'b0;
    s_rready <= 1'b0;
    hang(n);
  endtask
  // compare value set 100 counts ahead
  task automatic cmp_at(input int ch);
    rd(ADDR_COUNT);
    last = rd_d[15:0] + 16'h0064;
    wr(8'(ADDR_CMP0 + 4 * ch), {16'h0000, last});
  endtask
  task automatic wt(input logic [4:0] m, input logic [4:0] v);
    int n;
    n = 0;
    while ((pin_out & m) !== v && n < 300) begin
      @(posedge aclk);
      n++;
    end
    hang(n);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h0;
    s_wstrb = 4'hF;
    cap_in = 4'h0;
    bad_count = 0;
    compares = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 5; i++) begin
      rd(8'(ADDR_CMP0 + 4 * i));
      chk(rd_d, {16'h0000, CMP_RST});
    end
    wr(ADDR_CMP0 + 8'h08, 32'h0000ABCD);
    rd(ADDR_CMP0 + 8'h08);
    chk(rd_d, 32'h0000ABCD);
    wr(8'hF0, 32'h1);
    chk(rsp, RESP_SLVERR);
    rd(8'hF0);
    chk({rd_d, rsp}, {32'h0, RESP_SLVERR});
    // counter read-only, low byte latched
    rd(ADDR_COUNT);
    c0 = rd_d[15:0];
    wr(ADDR_COUNT, 32'h0);
    rd(ADDR_COUNT);
    chk(32'(rd_d[15:0] > c0), 32'h1);
    c0 = rd_d[15:0];
    rd(ADDR_LOBUF);
    chk(rd_d, {24'h0, c0[7:0]});
    // master channel drives masked pins, flag and irq
    wr(ADDR_IEN, 32'h80);
    wr(ADDR_MASK, 32'hF8);
    wr(ADDR_DATA, 32'hA8);
    cmp_at(0);
    wt(5'h1F, 5'h15);
    chk({pin_out, pin_oe}, {5'h15, 5'h1F});
    rd(ADDR_FLAG);
    chk(rd_d[7:4], 4'h8);
    chk(irq, 1'b1);
    wr(ADDR_FLAG, 32'h00);
    rd(ADDR_FLAG);
    chk(rd_d[7], 1'b1);
    wr(ADDR_FLAG, 32'h80);
    rd(ADDR_FLAG);
    chk({rd_d[7], irq}, 2'b00);
    wr(ADDR_MASK, 32'h00);
    // channel two modes, second toggle with flag left set
    for (i = 0; i < 4; i++) begin
      wr(ADDR_ACT, {24'h0, md[i], 6'h00});
      cmp_at(1);
      wt(5'h08, {1'b0, ev[i], 3'h0});
      chk(pin_out[3], ev[i]);
    end
    rd(ADDR_FLAG);
    chk(rd_d[6], 1'b1);
    // force drives pin without flag
    wr(ADDR_ACT, 32'hC0);
    wr(ADDR_FLAG, 32'hFF);
    wr(ADDR_FORCE, 32'h40);
    wt(5'h08, 5'h08);
    rd(ADDR_FLAG);
    chk({pin_out[3], rd_d[6]}, 2'b10);
    rd(ADDR_FORCE);
    chk(rd_d, 32'h0);
    // shared channel as fifth compare
    wr(ADDR_IEN, 32'h08);
    wr(ADDR_ACT, 32'h02);
    cmp_at(4);
    wt(5'h01, 5'h00);
    rd(ADDR_FLAG);
    chk({pin_out[0], rd_d[3], irq}, 3'b011);
    // shared channel as fourth capture
    wr(ADDR_FLAG, 32'hFF);
    wr(ADDR_SEL, 32'h04);
    wr(ADDR_CMP0 + 8'h10, 32'h5555);
    rd(ADDR_CMP0 + 8'h10);
    chk(rd_d, {16'h0000, last});
    wr(ADDR_EDGE, 32'h41);
    @(posedge aclk);
    cap_in <= 4'h9;
    repeat (8) @(posedge aclk);
    rd(ADDR_FLAG);
    chk({rd_d[3:2], irq}, 3'b111);
    rd(ADDR_CMP0 + 8'h10);
    chk(32'(rd_d[15:0] !== last), 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
